//--- logic/reset_and_activity_status.sv
// Reset sequencing, reset-status output and mode-dependent activity indicator.
// Assumes one 20 MHz clock; SRST models power-up; EXT_RESET_IN may change at any time.
`include "rst_seq_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module reset_and_activity_status
	import rst_seq_pkg::*;
#(
	parameter int unsigned CNT_W      = 24,
	parameter int unsigned POR_CYC    = `POR_CYCLES,
	parameter int unsigned EXT_DLY_CYC = `EXT_DELAY_CYCLES
) (
	input  wire logic              CLOCK,
	input  wire logic              SRST,
	input  wire logic              EXT_RESET_IN,
	input  wire logic [`MODE_W-1:0] MODE,
	input  wire logic              USB_CONFIGURED,
	input  wire logic              USB_DEV_ATTACHED,
	input  wire logic              CARD_LINK_OK,
	input  wire logic              HOST_IF_READY,
	output logic                   CORE_RESET,
	output logic                   CARD_SERIAL_OUT,
	output logic                   ACTIVITY_STATUS_N
);

	typedef struct packed {
		seq_state_t        state;
		logic [1:0]        ext_sync;
		logic [CNT_W-1:0]  cnt;
		logic              core_rst;
		logic              rst_status;
		logic              act_n;
	} st_t;

	localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_CYC - 1);
	localparam logic [CNT_W-1:0] EXT_LAST = CNT_W'(EXT_DLY_CYC - 1);

	st_t s_r;
	st_t s_nxt;
	op_mode_t mode;

	assign mode = op_mode_t'(MODE);

	always_comb begin
		s_nxt = s_r;
		// Release of the external reset passes two flops before use
		s_nxt.ext_sync = {s_r.ext_sync[0], 1'b0};
		case (s_r.state)
			ST_POR: begin
				if (s_r.cnt == POR_LAST) begin
					s_nxt.state = ST_INIT;
					s_nxt.cnt   = '0;
				end else begin
					s_nxt.cnt = s_r.cnt + CNT_W'(1);
				end
			end
			ST_HOLD: begin
				s_nxt.cnt = '0;
				if (!s_r.ext_sync[1]) begin
					s_nxt.state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (s_r.cnt == EXT_LAST) begin
					s_nxt.state = ST_INIT;
					s_nxt.cnt   = '0;
				end else begin
					s_nxt.cnt = s_r.cnt + CNT_W'(1);
				end
			end
			ST_INIT: begin
				if (HOST_IF_READY) begin
					s_nxt.state = ST_RUN;
				end
			end
			ST_RUN: begin
				s_nxt.state = ST_RUN;
			end
			default: begin
				s_nxt.state = ST_HOLD;
				s_nxt.cnt   = '0;
			end
		endcase

		s_nxt.core_rst   = (s_nxt.state == ST_POR) || (s_nxt.state == ST_HOLD)
			|| (s_nxt.state == ST_WAIT);
		s_nxt.rst_status = (s_nxt.state != ST_RUN);

		s_nxt.act_n = 1'b1;
		if (s_nxt.state == ST_RUN) begin
			case (mode)
				MD_USB_DEV:  s_nxt.act_n = !USB_CONFIGURED;
				MD_USB_HOST: s_nxt.act_n = !USB_DEV_ATTACHED;
				MD_SD_HOST:  s_nxt.act_n = !CARD_LINK_OK;
				default:     s_nxt.act_n = 1'b1;
			endcase
		end
	end

	// External reset takes the whole state at once; SRST restarts power-on timing
	always_ff @(posedge CLOCK or posedge EXT_RESET_IN) begin
		if (EXT_RESET_IN) begin
			s_r.state      <= ST_HOLD;
			s_r.ext_sync   <= 2'h3;
			s_r.cnt        <= '0;
			s_r.core_rst   <= 1'b1;
			s_r.rst_status <= 1'b1;
			s_r.act_n      <= 1'b1;
		end else if (SRST) begin
			s_r.state      <= ST_POR;
			s_r.ext_sync   <= 2'h0;
			s_r.cnt        <= '0;
			s_r.core_rst   <= 1'b1;
			s_r.rst_status <= 1'b1;
			s_r.act_n      <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign CORE_RESET        = s_r.core_rst;
	assign CARD_SERIAL_OUT   = s_r.rst_status;
	assign ACTIVITY_STATUS_N = s_r.act_n;

endmodule : reset_and_activity_status

`default_nettype wire

//--- logic/rst_seq_cfg.svh
// Timing and encoding constants for the reset sequencer and activity indicator.
// Assumes a single 20 MHz system clock.
// Functional notes
// - In USB device mode the activity output stays high while unconfigured or deconfigured.
// - In USB device mode the activity output goes low once the host has configured it.
// - In USB host mode the activity output is high while no downstream device is attached.
// - In USB host mode the activity output is low while a downstream device is attached.
// - In SD card host mode the activity output goes low once card communication works.
// - The block makes its own power-on reset without needing any external reset.
// - The external reset input is asynchronous, active high, and holds reset while high.
// - After the external reset falls, internal reset stays asserted about 35 ms more.
// - The reset-status output is high during power-on reset, forced reset and the delay.
// - The reset-status output falls only after reset ends and interface init completes.
// - The power-up reset lasts 25 to 40 ms, typically 35 ms.
`ifndef RST_SEQ_CFG_SVH
`define RST_SEQ_CFG_SVH

`define CLK_FREQ_MHZ     20
`define POR_TIME_US      35000
`define EXT_DELAY_US     35000
`define POR_CYCLES       (`POR_TIME_US * `CLK_FREQ_MHZ)
`define EXT_DELAY_CYCLES (`EXT_DELAY_US * `CLK_FREQ_MHZ)
`define MODE_W           2
`define MODE_NONE        2'h0
`define MODE_USB_DEV     2'h1
`define MODE_USB_HOST    2'h2
`define MODE_SD_HOST     2'h3

`endif

//--- logic/rst_seq_pkg.sv
// Types for the reset sequencer: sequence states and operating modes.
// Assumes rst_seq_cfg.svh supplies the mode encodings.
`include "rst_seq_cfg.svh"

package rst_seq_pkg;

	typedef enum logic [4:0] {
		ST_POR  = 5'h01,
		ST_HOLD = 5'h02,
		ST_WAIT = 5'h04,
		ST_INIT = 5'h08,
		ST_RUN  = 5'h10
	} seq_state_t;

	typedef enum logic [`MODE_W-1:0] {
		MD_NONE     = `MODE_NONE,
		MD_USB_DEV  = `MODE_USB_DEV,
		MD_USB_HOST = `MODE_USB_HOST,
		MD_SD_HOST  = `MODE_SD_HOST
	} op_mode_t;

endpackage : rst_seq_pkg

//--- bench/host_if_model.sv
// Host-interface model: ready lat cycles after core reset ends.
// Assumes the bench sets lat.
`timescale 1ns/1ps
`default_nettype none
module host_if_model (
	input  wire logic       CLOCK,
	input  wire logic       CORE_RESET,
	input  wire logic [3:0] lat,
	output logic            HOST_IF_READY
);
	logic [3:0] n_r;
	always_ff @(posedge CLOCK) n_r <= CORE_RESET ? 4'h0 : n_r + {3'h0, n_r < lat};
	assign HOST_IF_READY = !CORE_RESET && n_r >= lat;
endmodule : host_if_model
`default_nettype wire

//--- bench/rst_seq_chk.sv
// Checker on the sequencer top ports.
// Assumes POR_CYC 20, EXT_DLY_CYC 30.
`timescale 1ns/1ps
`default_nettype none
module rst_seq_chk (
	input wire logic       CLOCK,
	input wire logic       SRST,
	input wire logic       EXT_RESET_IN,
	input wire logic [1:0] MODE,
	input wire logic       USB_CONFIGURED,
	input wire logic       USB_DEV_ATTACHED,
	input wire logic       CARD_LINK_OK,
	input wire logic       CORE_RESET,
	input wire logic       CARD_SERIAL_OUT,
	input wire logic       ACTIVITY_STATUS_N
);
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (SRST);
	ext_hold_a: assert property (EXT_RESET_IN |-> CORE_RESET && CARD_SERIAL_OUT)
		else $error("hold");
	stat_hold_a: assert property (CORE_RESET |-> CARD_SERIAL_OUT)
		else $error("stat");
	act_idle_a: assert property (CARD_SERIAL_OUT |-> ACTIVITY_STATUS_N)
		else $error("idle");
	dev_act_a: assert property (!CARD_SERIAL_OUT && !$past(CARD_SERIAL_OUT)
		&& $past(MODE) == 2'h1 |-> ACTIVITY_STATUS_N == !$past(USB_CONFIGURED)) else $error("dev");
	host_act_a: assert property (!CARD_SERIAL_OUT && !$past(CARD_SERIAL_OUT)
		&& $past(MODE) == 2'h2 |-> ACTIVITY_STATUS_N == !$past(USB_DEV_ATTACHED)) else $error("hst");
	sd_act_a: assert property (!CARD_SERIAL_OUT && !$past(CARD_SERIAL_OUT)
		&& $past(MODE) == 2'h3 |-> ACTIVITY_STATUS_N == !$past(CARD_LINK_OK)) else $error("sd");
	por_len_a: assert property ($fell(SRST) |-> ##17 CORE_RESET ##[1:5] !CORE_RESET)
		else $error("por");
	ext_dly_a: assert property ($fell(EXT_RESET_IN) |-> ##30 CORE_RESET ##[1:4] !CORE_RESET)
		else $error("dly");
endmodule : rst_seq_chk
bind reset_and_activity_status rst_seq_chk u_rst_seq_chk (.*);
`default_nettype wire

//--- bench/tb.sv
// Bench: random mode traffic and resets.
// Assumes the design, model and checker.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        CLOCK = 0, SRST = 1, EXT_RESET_IN = 0, USB_CONFIGURED = 0, USB_DEV_ATTACHED = 0;
	logic        CARD_LINK_OK = 0, HOST_IF_READY, CORE_RESET, CARD_SERIAL_OUT, ACTIVITY_STATUS_N;
	logic [1:0]  MODE = 2'h0;
	logic [3:0]  lat = 4'h2;
	logic [15:0] lf = 16'hE42A;
	int          fail_count = 0, n_tests = 0, k;
	reset_and_activity_status #(.POR_CYC(20), .EXT_DLY_CYC(30)) u_reset_and_activity_status (.*);
	host_if_model u_host_if_model (.CLOCK, .CORE_RESET, .lat, .HOST_IF_READY);
	initial forever #25 CLOCK = ~CLOCK;
	task automatic chk(logic [7:0] g, logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wrap_up;
		if (fail_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : wrap_up
	function automatic logic [15:0] lfsr_next(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr_next
	task automatic wt;
		for (k = 0; CORE_RESET !== 1'b0 && k < 99; k++) @(negedge CLOCK);
	endtask : wt
	task automatic traffic;
		repeat (60) begin
			@(negedge CLOCK);
			lf = lfsr_next(lf);
			{MODE, USB_CONFIGURED, USB_DEV_ATTACHED, CARD_LINK_OK} = lf[4:0];
			@(negedge CLOCK);
			chk(ACTIVITY_STATUS_N, MODE == 2'h1 ? !USB_CONFIGURED : MODE == 2'h2 ?
				!USB_DEV_ATTACHED : MODE == 2'h3 ? !CARD_LINK_OK : 1'b1);
		end
	endtask : traffic
	task automatic ext_pulse(logic [3:0] l);
		@(negedge CLOCK);
		EXT_RESET_IN = 1;
		lat = l;
		#1 chk({CORE_RESET, CARD_SERIAL_OUT, ACTIVITY_STATUS_N}, 8'h07);
		@(negedge CLOCK);
		EXT_RESET_IN = 0;
		wt();
		chk(k[7:0], 8'h21);
		chk(CARD_SERIAL_OUT, 8'h01);
		repeat (l + 2) @(negedge CLOCK);
		chk(CARD_SERIAL_OUT, 8'h00);
		traffic();
	endtask : ext_pulse
	initial begin
		repeat (6) @(negedge CLOCK);
		SRST = 0;
		wt();
		repeat (5) @(negedge CLOCK);
		chk(CARD_SERIAL_OUT, 8'h00);
		traffic();
		ext_pulse(4'h0);
		ext_pulse(4'hB);
		SRST = 1;
		@(negedge CLOCK);
		chk({CORE_RESET, CARD_SERIAL_OUT}, 8'h03);
		SRST = 0;
		wt();
		// Host model latency is still long here; wait until the run state is reached
		repeat (16) @(negedge CLOCK);
		chk(CARD_SERIAL_OUT, 8'h00);
		traffic();
		wrap_up();
	end
	initial begin
		#200000;
		fail_count++;
		wrap_up();
	end
endmodule : tb
`default_nettype wire
